/* File: scs_pkg.sv */
package scs_pkg;
    // Input and function code widths
    localparam int NUM_INPUTS = 6;
    localparam int FUNC_W = 8;
    localparam int SPEED_W = 16;
    localparam int MODE_W = 4;

    // Function codes assigned to digital inputs
    localparam logic [7:0] FUNC_NONE = 8'h00;
    localparam logic [7:0] FUNC_SERVO_ENABLE = 8'h65;
    localparam logic [7:0] FUNC_ALARM_CLEAR = 8'h66;
    localparam logic [7:0] FUNC_TORQUE_LIMIT = 8'h6D;
    localparam logic [7:0] FUNC_SPEED_SEL0 = 8'h72;
    localparam logic [7:0] FUNC_SPEED_SEL1 = 8'h73;
    localparam logic [7:0] FUNC_EMERGENCY_STOP = 8'h15;
    localparam logic [7:0] FUNC_REVERSE_INHIBIT = 8'h16;
    localparam logic [7:0] FUNC_FORWARD_INHIBIT = 8'h17;

    // Operating mode value selecting speed control
    localparam logic [3:0] MODE_SPEED = 4'h4;
    localparam logic [3:0] MODE_RESET = 4'h0;

    // Speed limits and jog default, in rpm
    localparam logic signed [15:0] SPEED_MAX = 16'sh1388;
    localparam logic signed [15:0] SPEED_MIN = -16'sh1388;
    localparam logic signed [15:0] JOG_SPEED_DEFAULT = 16'sh0014;
    localparam logic signed [15:0] ZERO_SPEED = 16'sh0000;

    // Decoded input functions
    typedef struct packed {
        logic servo_enable;
        logic torque_limit;
        logic speed_sel_bit0;
        logic speed_sel_bit1;
        logic alarm_clear;
        logic emergency_stop;
        logic reverse_inhibit;
        logic forward_inhibit;
    } scs_func_t;

    // Fault flags
    typedef struct packed {
        logic emergency_stop_fault;
        logic reverse_inhibit_fault;
        logic forward_inhibit_fault;
    } scs_fault_t;
endpackage

/* File: scs_speed_selector.sv */
`timescale 1ns/1ps
// Summary of operation
// - Mode value 4 selects speed control
// - Mode change applies only after restart
// - Codes 114/115 are speed select bits
// - 101 enable, 102 alarm clear, 0 none
// - Inputs 4-6 default inhibit/stop, raise faults; inhibits raise none while jogging
// - Both select bits off gives zero
// - Bit0 only uses preset one, clamp 5000
// - Bit1 only uses preset two
// - Both bits use preset three, signed
// - Level 0 off, level 1 on
// - Alarm cleared by restart or clear input
// - Servo enable input runs the drive
// - Jog speed defaults 20, digit steps
// - Jog up forward, down reverse
// - Jog refused on emergency stop only
module scs_speed_selector (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Digital input pins
    input wire logic [5:0] din_pins,
    // Input function parameters, one code per input
    input wire logic [47:0] input_function_params,
    // Mode and preset speeds
    input wire logic [3:0] operating_mode_param,
    input wire logic signed [15:0] preset_speed_one,
    input wire logic signed [15:0] preset_speed_two,
    input wire logic signed [15:0] preset_speed_three,
    // Keypad jog controls, one-cycle key pulses and held keys
    input wire logic jog_enter,
    input wire logic jog_exit,
    input wire logic jog_inc,
    input wire logic jog_dec,
    input wire logic jog_shift,
    input wire logic jog_up_key,
    input wire logic jog_down_key,
    // Outputs
    output logic speed_ctrl_mode,
    output logic drive_enable,
    output logic torque_limit_active,
    output logic signed [15:0] speed_command,
    output logic [2:0] fault_flags,
    output logic alarm_active,
    output logic jog_active,
    output logic signed [15:0] jog_speed_param
);
    // Pin synchronisers
    logic [5:0] sync1_q, sync1_d, sync2_q, sync2_d;
    // Latched mode and resulting flag
    logic [3:0] mode_q, mode_d;
    logic mode_loaded_q, mode_loaded_d;
    logic speed_mode_q, speed_mode_d;
    // Registered outputs
    logic drive_q, drive_d;
    logic trq_q, trq_d;
    logic signed [15:0] cmd_q, cmd_d;
    scs_pkg::scs_fault_t fault_q, fault_d;
    // Registered alarm summary, so the pin comes from a flop
    logic alarm_q, alarm_d;
    logic jog_q, jog_d;
    logic signed [15:0] jog_spd_q, jog_spd_d;
    logic [15:0] jog_step_q, jog_step_d;
    // Decoded functions
    scs_pkg::scs_func_t func;
    logic [5:0] hit_en, hit_trq, hit_s0, hit_s1, hit_clr, hit_es, hit_rv, hit_fw;

    // Per-input function decode; a high level means on
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_dec
            logic [7:0] code;
            logic lvl;
            assign code = input_function_params[gi*8 +: 8];
            assign lvl = sync2_q[gi];
            assign hit_en[gi] = lvl && (code == scs_pkg::FUNC_SERVO_ENABLE);
            assign hit_clr[gi] = lvl && (code == scs_pkg::FUNC_ALARM_CLEAR);
            assign hit_trq[gi] = lvl && (code == scs_pkg::FUNC_TORQUE_LIMIT);
            assign hit_s0[gi] = lvl && (code == scs_pkg::FUNC_SPEED_SEL0);
            assign hit_s1[gi] = lvl && (code == scs_pkg::FUNC_SPEED_SEL1);
            assign hit_es[gi] = lvl && (code == scs_pkg::FUNC_EMERGENCY_STOP);
            assign hit_rv[gi] = lvl && (code == scs_pkg::FUNC_REVERSE_INHIBIT);
            assign hit_fw[gi] = lvl && (code == scs_pkg::FUNC_FORWARD_INHIBIT);
        end
    endgenerate

    // Collapse per-input hits into functions
    always_comb begin
        func.servo_enable = |hit_en;
        func.torque_limit = |hit_trq;
        func.speed_sel_bit0 = |hit_s0;
        func.speed_sel_bit1 = |hit_s1;
        func.alarm_clear = |hit_clr;
        func.emergency_stop = |hit_es;
        func.reverse_inhibit = |hit_rv;
        func.forward_inhibit = |hit_fw;
    end

    // Next-state logic
    always_comb begin
        // Two-stage synchroniser on the pins
        sync1_d = din_pins;
        sync2_d = sync1_q;
        // Mode is captured once after reset release only
        mode_loaded_d = 1'b1;
        mode_d = mode_loaded_q ? mode_q : operating_mode_param;
        // Speed mode flag follows the latched value one cycle later
        speed_mode_d = mode_loaded_q && (mode_q == scs_pkg::MODE_SPEED);
        // Drive runs with servo enable or while jogging
        drive_d = func.servo_enable || jog_q;
        // Torque limit follows its input
        trq_d = func.torque_limit;
        // Preset speed selection; all four codes are legal
        unique case ({func.speed_sel_bit1, func.speed_sel_bit0})
            2'b00: cmd_d = scs_pkg::ZERO_SPEED;
            2'b01: cmd_d = preset_speed_one;
            2'b10: cmd_d = preset_speed_two;
            2'b11: cmd_d = preset_speed_three;
        endcase
        // Clamp to the signed preset range
        if (cmd_d > scs_pkg::SPEED_MAX) begin
            cmd_d = scs_pkg::SPEED_MAX;
        end else if (cmd_d < scs_pkg::SPEED_MIN) begin
            cmd_d = scs_pkg::SPEED_MIN;
        end
        // Outside speed mode or with the servo off, no preset command; jogging sets the command below
        if (!speed_mode_q || !func.servo_enable) begin
            cmd_d = scs_pkg::ZERO_SPEED;
        end
        // Faults: sticky, the set wins over the clear
        fault_d = fault_q;
        // Alarm clear wipes every flag, then new sets win
        if (func.alarm_clear) begin
            fault_d = '0;
        end
        if (func.emergency_stop) fault_d.emergency_stop_fault = 1'b1;
        // Inhibits raise no fault while jogging
        if (func.reverse_inhibit && !jog_q) fault_d.reverse_inhibit_fault = 1'b1;
        if (func.forward_inhibit && !jog_q) fault_d.forward_inhibit_fault = 1'b1;
        // Alarm summary follows the next fault state
        alarm_d = |fault_d;
        // Jog mode entry and exit; entry refused while a stop is active or latched
        jog_d = jog_q;
        jog_spd_d = jog_spd_q;
        jog_step_d = jog_step_q;
        if (!jog_q && jog_enter && !fault_q.emergency_stop_fault && !func.emergency_stop) begin
            jog_d = 1'b1;
            jog_spd_d = scs_pkg::JOG_SPEED_DEFAULT;
            jog_step_d = 16'h0001;
        end else if (jog_q) begin
            // Leave on the exit key or on an emergency stop
            if (jog_exit || func.emergency_stop) begin
                jog_d = 1'b0;
            end
            // Shift moves the edited digit up one decade, wrapping from 1000 back to 1
            if (jog_shift) begin
                jog_step_d = (jog_step_q >= 16'h03E8) ? 16'h0001 : 16'(jog_step_q * 16'h000A);
            end
            // Step the speed, kept between one and the limit
            if (jog_inc && (jog_spd_q <= scs_pkg::SPEED_MAX - $signed(jog_step_q))) begin
                jog_spd_d = jog_spd_q + $signed(jog_step_q);
            end else if (jog_dec && (jog_spd_q > $signed(jog_step_q))) begin
                jog_spd_d = jog_spd_q - $signed(jog_step_q);
            end
            // Held keys drive forward or reverse at jog speed
            if (jog_up_key && !jog_down_key) begin
                cmd_d = jog_spd_q;
            end else if (jog_down_key && !jog_up_key) begin
                cmd_d = -jog_spd_q;
            end else begin
                cmd_d = scs_pkg::ZERO_SPEED;
            end
        end
    end

    // State registers
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            // Reset values; the jog speed starts at its default
            sync1_q <= '0;
            sync2_q <= '0;
            mode_q <= scs_pkg::MODE_RESET;
            mode_loaded_q <= 1'b0;
            speed_mode_q <= 1'b0;
            drive_q <= 1'b0;
            trq_q <= 1'b0;
            cmd_q <= scs_pkg::ZERO_SPEED;
            fault_q <= '0;
            jog_q <= 1'b0;
            jog_spd_q <= scs_pkg::JOG_SPEED_DEFAULT;
            jog_step_q <= 16'h0001;
            alarm_q <= 1'b0;
        end else begin
            // Take the next values
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            mode_q <= mode_d;
            mode_loaded_q <= mode_loaded_d;
            speed_mode_q <= speed_mode_d;
            drive_q <= drive_d;
            trq_q <= trq_d;
            cmd_q <= cmd_d;
            fault_q <= fault_d;
            jog_q <= jog_d;
            jog_spd_q <= jog_spd_d;
            jog_step_q <= jog_step_d;
            alarm_q <= alarm_d;
        end
    end

    // Outputs straight from flops
    assign speed_ctrl_mode = speed_mode_q;
    assign drive_enable = drive_q;
    assign torque_limit_active = trq_q;
    assign speed_command = cmd_q;
    assign fault_flags = fault_q;
    assign alarm_active = alarm_q;
    assign jog_active = jog_q;
    assign jog_speed_param = jog_spd_q;
endmodule // scs_speed_selector

/* File: scs_ctrl_model.sv */
`timescale 1ns/1ps
module scs_ctrl_model (
    // Clock
    input wire logic mclk,
    // Wanted levels and pacing
    input wire logic [5:0] want,
    input wire logic slow,
    // Pins to the drive
    output logic [5:0] din_pins
);
    logic [5:0] stage_q; // Slow contact stage
    // Contacts settle one or two cycles late
    always_ff @(posedge mclk) begin
        stage_q <= want;
        din_pins <= slow ? stage_q : want;
    end
endmodule // scs_ctrl_model

/* File: scs_speed_selector_asserts.sv */
`timescale 1ns/1ps
module scs_speed_selector_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Keys
    input wire logic jog_enter,
    input wire logic jog_up_key,
    input wire logic jog_down_key,
    // Outputs
    input wire logic speed_ctrl_mode,
    input wire logic drive_enable,
    input wire logic signed [15:0] speed_command,
    input wire logic [2:0] fault_flags,
    input wire logic alarm_active,
    input wire logic jog_active,
    input wire logic signed [15:0] jog_speed_param
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // Up key held alone while jogging
    sequence s_up;
        jog_active && jog_up_key && !jog_down_key;
    endsequence
    // Down key held alone while jogging
    sequence s_dn;
        jog_active && jog_down_key && !jog_up_key;
    endsequence
    AST_UP_FWD: assert property (s_up ##1 jog_active |-> speed_command == $past(jog_speed_param))
        else $error("jog up speed wrong");
    AST_DN_REV: assert property (s_dn ##1 jog_active |-> speed_command == -$past(jog_speed_param))
        else $error("jog down speed wrong");
    AST_MODE_HOLD: assert property ($past(resetn, 3) |-> $stable(speed_ctrl_mode))
        else $error("mode changed without restart");
    AST_CLAMP: assert property (speed_command <= 16'sh1388 && speed_command >= -16'sh1388)
        else $error("command out of range");
    AST_OFF_ZERO: assert property ((!drive_enable)[*2] |-> speed_command == 16'sh0000)
        else $error("command while disabled");
    AST_MODE_ZERO: assert property ((!speed_ctrl_mode && !jog_active)[*2] |-> speed_command == 16'sh0000)
        else $error("command outside speed mode");
    AST_ALARM: assert property ((|fault_flags) |-> ##[0:1] alarm_active)
        else $error("fault without alarm");
    AST_JOG_EMG: assert property (fault_flags[2] && jog_enter |=> !$rose(jog_active))
        else $error("jog entered on stop fault");
    AST_JOG_DRV: assert property (jog_active |=> drive_enable)
        else $error("jog without drive");
endmodule // scs_speed_selector_asserts
bind scs_speed_selector scs_speed_selector_asserts u_chk (.mclk, .resetn, .jog_enter, .jog_up_key,
    .jog_down_key, .speed_ctrl_mode, .drive_enable, .speed_command, .fault_flags, .alarm_active,
    .jog_active, .jog_speed_param);

/* File: scs_tb.sv */
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic slow = 1'b0;
    logic tl;
    logic [5:0] want = 6'h00; // Wanted pin levels
    logic [5:0] din; // Pins from the model
    logic [6:0] key = 7'h00; // enter exit inc dec shift up down
    logic [47:0] fp; // Function codes
    logic [3:0] mode = 4'h4;
    logic signed [15:0] p1 = 16'sh0000, p2 = 16'sh0000, p3 = 16'sh0000, cmd, jsp;
    logic signed [15:0] v [4];
    logic sm, de, tla, al, ja;
    logic [2:0] ff;
    logic [7:0][15:0] obs; // Watched outputs by index
    logic signed [15:0] expq [$];
    int selq [$];
    int seed = 18968, bad_count = 0, n_tests = 0, cyc = 0;
    assign obs = {{13'h0000, ff}, {15'h0000, de}, {15'h0000, tla}, {15'h0000, sm}, jsp,
        {15'h0000, ja}, {15'h0000, al}, cmd};
    scs_ctrl_model u_ctrl (.mclk(mclk), .want(want), .slow(slow), .din_pins(din));
    scs_speed_selector dut (.mclk(mclk), .resetn(resetn), .din_pins(din),
        .input_function_params(fp), .operating_mode_param(mode), .preset_speed_one(p1),
        .preset_speed_two(p2), .preset_speed_three(p3), .jog_enter(key[0]), .jog_exit(key[1]),
        .jog_inc(key[2]), .jog_dec(key[3]), .jog_shift(key[4]), .jog_up_key(key[5]),
        .jog_down_key(key[6]), .speed_ctrl_mode(sm), .drive_enable(de),
        .torque_limit_active(tla), .speed_command(cmd), .fault_flags(ff), .alarm_active(al),
        .jog_active(ja), .jog_speed_param(jsp));
    // Clock
    initial begin
        forever #2.5 mclk = ~mclk;
    end
    task check(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            bad_count++;
            $display("Error at %0t: got %0h expected %0h", $time, s, e);
        end
    endtask
    task report_and_stop();
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task note(input int w, input logic [15:0] e);
        expq.push_back(e);
        selq.push_back(w);
    endtask
    task wait_n(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task do_reset();
        @(posedge mclk);
        resetn <= 1'b0;
        wait_n(16);
        resetn <= 1'b1;
        wait_n(4);
    endtask
    task press(input int i);
        @(posedge mclk);
        key[i] <= 1'b1;
        @(posedge mclk);
        key[i] <= 1'b0;
        wait_n(3);
    endtask
    // Monitor drains all queued notes, oldest first, when results are settled
    always @(negedge mclk) begin
        while (selq.size() > 0) check(obs[selq.pop_front()], expq.pop_front());
    end
    // Hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            report_and_stop();
        end
    end
    initial begin
        fp = {scs_pkg::FUNC_NONE, scs_pkg::FUNC_ALARM_CLEAR, scs_pkg::FUNC_SPEED_SEL1,
            scs_pkg::FUNC_SPEED_SEL0, scs_pkg::FUNC_TORQUE_LIMIT, scs_pkg::FUNC_SERVO_ENABLE};
        wait_n(16);
        resetn <= 1'b1;
        wait_n(4);
        note(3, 16'sh0014);
        note(4, 16'sh0001);
        for (int i = 0; i < 8; i++) begin
            v[0] = 16'sh0000;
            v[1] = 16'($random(seed) % 5000);
            v[2] = 16'($random(seed) % 5000);
            v[3] = i[0] ? -16'sh1388 : 16'($random(seed) % 5000);
            tl = 1'($random(seed) & 1);
            @(posedge mclk);
            {p3, p2, p1} <= {v[3], v[2], v[1]};
            want <= {2'b00, i[1], i[0], tl, ~i[2]};
            slow <= i[0];
            wait_n(7);
            note(0, i[2] ? 16'sh0000 : v[i[1:0]]);
            note(5, {15'h0000, tl});
            note(6, {15'h0000, ~i[2]});
        end
        p3 <= 16'sh7FFF;
        want <= 6'h0D;
        wait_n(7);
        note(0, 16'sh1388);
        p3 <= -16'sh7FFF;
        wait_n(3);
        note(0, -16'sh1388);
        $display("Test selects done");
        mode <= 4'h0;
        wait_n(4);
        note(4, 16'sh0001);
        do_reset();
        want <= 6'h05;
        wait_n(7);
        note(4, 16'sh0000);
        note(0, 16'sh0000);
        want <= 6'h04;
        wait_n(7);
        mode <= 4'h4;
        do_reset();
        want <= 6'h20;
        wait_n(7);
        note(1, 16'sh0000);
        fp[47:40] <= scs_pkg::FUNC_EMERGENCY_STOP;
        wait_n(7);
        note(1, 16'sh0001);
        note(7, 16'h0004);
        press(0);
        note(2, 16'sh0000);
        want <= 6'h10;
        wait_n(7);
        note(1, 16'sh0000);
        note(7, 16'h0000);
        want <= 6'h00;
        wait_n(7);
        $display("Test faults done");
        press(0);
        note(2, 16'sh0001);
        note(6, 16'h0001);
        key[5] <= 1'b1;
        wait_n(3);
        note(0, 16'sh0014);
        key[5] <= 1'b0;
        key[6] <= 1'b1;
        wait_n(3);
        note(0, -16'sh0014);
        key[6] <= 1'b0;
        press(2);
        note(3, 16'sh0015);
        press(4);
        press(2);
        note(3, 16'sh001F);
        fp[47:40] <= scs_pkg::FUNC_REVERSE_INHIBIT;
        want <= 6'h20;
        wait_n(7);
        note(2, 16'sh0001);
        note(7, 16'h0000);
        want <= 6'h00;
        wait_n(7);
        press(1);
        note(2, 16'sh0000);
        note(6, 16'h0000);
        $display("Test jog done");
        wait_n(2);
        report_and_stop();
    end
endmodule // testbench
